// ---- shared/sscr_pkg.sv ----
/*
  Constants for the sensor setup and calibration register bank: serial
  address, register offsets, field positions, reset values and the
  factory calibration table.
  Assumes nothing beyond a SystemVerilog compiler; nothing is imported.
*/
`default_nettype none

package sscr_pkg;

  // Serial slave address of the device (value is arbitrary)
  localparam logic [6:0] I2C_DEV_ADDR = 7'h5a;

  // Register offsets on the serial register pointer
  localparam logic [7:0] REG_OTP_CTRL = 8'h08;
  localparam logic [7:0] REG_SETUP = 8'h0a;
  localparam logic [7:0] REG_PR_COEFF = 8'h22;
  localparam logic [7:0] REG_PR_OFFSET = 8'h24;
  localparam logic [7:0] REG_TEMP_FIRST = 8'h26;
  localparam logic [7:0] REG_TEMP_LAST = 8'h2a;
  localparam logic [7:0] REG_THERM_FIRST = 8'h2c;
  localparam logic [7:0] REG_THERM_OFFSET = 8'h32;
  localparam logic [7:0] REG_EXT = 8'h34;
  localparam logic [7:0] OTP_FIRST = 8'h20;
  localparam logic [7:0] OTP_LAST = 8'h35;

  // Setup register: power-up field in bits 1..0, upper bits read zero
  localparam int SETUP_W = 2;
  localparam logic [1:0] SETUP_START = 2'h2;
  localparam logic [5:0] SETUP_RESV = 6'h00;

  // Read-control register: read-disable in bit 6, fixed reserved bits
  localparam int OTP_DIS_BIT = 6;
  localparam logic OTP_DIS_RESET = 1'h1;
  localparam logic [7:0] OTP_CTRL_RESV = 8'h25;

  // Serial framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] LAST_OUT_BIT = 3'h7;

  // Calibration memory geometry
  localparam int CAL_AW = 4;
  localparam int CAL_DW = 16;
  localparam int CAL_DEPTH = 16;

  // Factory calibration words, indexed by (offset - 20h) / 2 (values arbitrary)
  localparam logic [CAL_DW-1:0] CAL_WORDS [0:CAL_DEPTH-1] = '{
    16'h0000, 16'h1a2b, 16'h3c4d, 16'h5e6f, 16'h7081, 16'h92a3,
    16'hb4c5, 16'hd6e7, 16'hf809, 16'h1b2c, 16'h3d4e, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000};

endpackage

`default_nettype wire

// ---- shared/sscr_otp_if.sv ----
/*
  Carrier between the register bank and its calibration memory: a word
  index going in and a registered 16-bit word coming back.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

interface sscr_otp_if;
  logic [sscr_pkg::CAL_AW-1:0] addr;
  logic [sscr_pkg::CAL_DW-1:0] data;

  // Register bank asks, memory answers
  modport bank (output addr, input data);
  modport rom (input addr, output data);
endinterface

`default_nettype wire

// ---- rtl/sscr_pin_sync.sv ----
/*
  Two-flop synchroniser for the serial clock and data pins.
  Assumes the pins are asynchronous to clock_i; only the second stage
  is visible outside.
*/
`timescale 1ns/100ps
`default_nettype none

module sscr_pin_sync (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [1:0] raw_i,
  output logic [1:0] sync_o
);

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
  } sscr_sync_s;

  sscr_sync_s s_q;
  sscr_sync_s s_d;

  // Idle bus level is high on both lines
  always_comb begin
    s_d = s_q;
    s_d.meta = raw_i;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_q <= '{meta: 2'h3, stable: 2'h3};
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_o = s_q.stable;

endmodule // sscr_pin_sync

`default_nettype wire

// ---- rtl/sscr_otp_rom.sv ----
/*
  Calibration memory: read-only factory words with registered read data.
  Assumes the index is held stable for at least one clock before use.
*/
`timescale 1ns/100ps
`default_nettype none

module sscr_otp_rom (
  input wire logic clock_i,
  input wire logic rst_i,
  sscr_otp_if.rom port
);

  typedef struct packed {
    logic [sscr_pkg::CAL_DW-1:0] rdata;
  } sscr_rom_s;

  sscr_rom_s s_q;
  sscr_rom_s s_d;

  // Look up the word; no write path exists
  always_comb begin
    s_d = s_q;
    s_d.rdata = sscr_pkg::CAL_WORDS[port.addr];
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign port.data = s_q.rdata;

endmodule // sscr_otp_rom

`default_nettype wire

// ---- rtl/sscr_regs_top.sv ----
/*
  Serial slave register bank of the pressure sensor: ADC power-up setup,
  calibration read gate and read-only calibration words.
  Calibration reads are gated by the read-disable bit; writes to them are dropped.
  Assumes an open-drain two-wire bus whose pins are asynchronous to
  clock_i, and a clock at least ten times the serial bit rate.
*/
`timescale 1ns/100ps
`default_nettype none

module sscr_regs_top #(
  parameter logic [6:0] DEV_ADDR = sscr_pkg::I2C_DEV_ADDR
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic [1:0] adc_powerup_o,
  output logic adc_setup_start_o,
  output logic otp_read_enable_o
);

  // Serial slave states, Gray coded along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ADDR_ACK = 3'h3,
    ST_WR_BYTE = 3'h2,
    ST_WR_ACK = 3'h6,
    ST_RD_BYTE = 3'h7,
    ST_RD_ACK = 3'h5
  } sscr_state_e;

  // Complete state of the slave; one comb copy, one register
  typedef struct packed {
    sscr_state_e st;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic rw;
    logic first;
    logic ack_ok;
    logic scl_prev;
    logic sda_prev;
    logic sda_out;
    logic sda_oe_n;
    logic otp_dis;
    logic otp_en;
    logic [1:0] setup;
    logic adc_start;
  } sscr_top_s;

  // Reset image: bus released, read gate shut, start code loaded
  localparam sscr_top_s RESET_STATE = '{
    st: ST_IDLE,
    bit_cnt: 4'h0,
    shift: 8'h00,
    ptr: 8'h00,
    rw: 1'h0,
    first: 1'h0,
    ack_ok: 1'h0,
    scl_prev: 1'h1,
    sda_prev: 1'h1,
    sda_out: 1'h0,
    sda_oe_n: 1'h1,
    otp_dis: sscr_pkg::OTP_DIS_RESET,
    otp_en: !sscr_pkg::OTP_DIS_RESET,
    setup: sscr_pkg::SETUP_START,
    adc_start: 1'h1
  };

  sscr_top_s s_q;
  sscr_top_s s_d;
  // Synchronised pin levels and derived bus events
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] tx_byte;

  // Carrier to the calibration memory
  sscr_otp_if otp_bus ();

  // Pin synchroniser, second stage only
  sscr_pin_sync i_sscr_pin_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .raw_i({scl_i, sda_i}),
    .sync_o(pins_s)
  );

  // Calibration memory with registered read data
  sscr_otp_rom i_sscr_otp_rom (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .port(otp_bus.rom)
  );

  // True when the pointer lies in the calibration window
  function automatic logic in_otp_f(input logic [7:0] ptr);
    in_otp_f = (ptr >= sscr_pkg::OTP_FIRST) && (ptr <= sscr_pkg::OTP_LAST);
  endfunction

  // Byte returned for a pointer; calibration words split high then low
  // Unmapped offsets and gated calibration reads return zero
  function automatic logic [7:0] read_byte_f(
    input logic [7:0] ptr,
    input logic otp_dis,
    input logic [1:0] setup,
    input logic [15:0] word
  );
    logic [7:0] res;
    res = 8'h00;
    if (ptr == sscr_pkg::REG_OTP_CTRL) begin
      res = sscr_pkg::OTP_CTRL_RESV;
      res[sscr_pkg::OTP_DIS_BIT] = otp_dis;
    end else if (ptr == sscr_pkg::REG_SETUP) begin
      res = {sscr_pkg::SETUP_RESV, setup};
    end else if (in_otp_f(ptr) && !otp_dis) begin
      // Unsigned raw bits, even offset gives the upper byte
      res = ptr[0] ? word[7:0] : word[15:8];
    end
    read_byte_f = res;
  endfunction

  // Word index of the calibration memory follows the pointer
  // Memory data lag the pointer by one clock; the bus leaves ample time
  assign otp_bus.addr = s_q.ptr[sscr_pkg::CAL_AW:1];

  // Bus events from the synchronised pins
  // Start and stop are data edges while the clock stays high
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];
  assign scl_rise = scl_s && !s_q.scl_prev;
  assign scl_fall = !scl_s && s_q.scl_prev;
  assign bus_start = scl_s && s_q.scl_prev && s_q.sda_prev && !sda_s;
  assign bus_stop = scl_s && s_q.scl_prev && !s_q.sda_prev && sda_s;
  assign tx_byte = read_byte_f(s_q.ptr, s_q.otp_dis, s_q.setup, otp_bus.data);

  // Serial slave and register writes
  always_comb begin
    s_d = s_q;
    s_d.scl_prev = scl_s;
    s_d.sda_prev = sda_s;
    if (bus_start) begin
      // A start, repeated or not, restarts address collection
      s_d.st = ST_ADDR;
      s_d.bit_cnt = 4'h0;
      s_d.sda_oe_n = 1'h1;
    end else if (bus_stop) begin
      // A stop ends any transfer and frees the data pin
      s_d.st = ST_IDLE;
      s_d.sda_oe_n = 1'h1;
    end else begin
      case (s_q.st)
        ST_IDLE: begin
          // Wait for a start; the data pin stays released
          s_d.sda_oe_n = 1'h1;
        end
        ST_ADDR: begin
          // Collect address and direction, answer only our own address
          if (scl_rise) begin
            s_d.shift = {s_q.shift[6:0], sda_s};
            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
          end else if (scl_fall && s_q.bit_cnt == sscr_pkg::BITS_PER_BYTE) begin
            s_d.bit_cnt = 4'h0;
            if (s_q.shift[7:1] == DEV_ADDR) begin
              s_d.rw = s_q.shift[0];
              s_d.sda_oe_n = 1'h0;
              s_d.st = ST_ADDR_ACK;
            end else begin
              // Another device is addressed: stay off the bus
              s_d.st = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          // Acknowledge held until the host's clock falls
          if (scl_fall) begin
            s_d.bit_cnt = 4'h0;
            if (s_q.rw) begin
              // Put the first bit of the addressed byte on the line
              s_d.shift = tx_byte;
              s_d.sda_oe_n = tx_byte[7];
              s_d.st = ST_RD_BYTE;
            end else begin
              s_d.sda_oe_n = 1'h1;
              s_d.first = 1'h1;
              s_d.st = ST_WR_BYTE;
            end
          end
        end
        ST_WR_BYTE: begin
          // Bits are taken on the rising clock edge
          if (scl_rise) begin
            s_d.shift = {s_q.shift[6:0], sda_s};
            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
          end else if (scl_fall && s_q.bit_cnt == sscr_pkg::BITS_PER_BYTE) begin
            s_d.sda_oe_n = 1'h0;
            s_d.st = ST_WR_ACK;
            if (s_q.first) begin
              // First byte after the address sets the pointer
              s_d.ptr = s_q.shift;
              s_d.first = 1'h0;
            end else begin
              // Only the two control fields take writes; calibration ignores them
              if (s_q.ptr == sscr_pkg::REG_OTP_CTRL) begin
                s_d.otp_dis = s_q.shift[sscr_pkg::OTP_DIS_BIT];
              end else if (s_q.ptr == sscr_pkg::REG_SETUP) begin
                s_d.setup = s_q.shift[sscr_pkg::SETUP_W-1:0];
              end
              s_d.ptr = s_q.ptr + 8'h01;
            end
          end
        end
        ST_WR_ACK: begin
          // Release after the acknowledge clock, ready for the next byte
          if (scl_fall) begin
            s_d.sda_oe_n = 1'h1;
            s_d.bit_cnt = 4'h0;
            s_d.st = ST_WR_BYTE;
          end
        end
        ST_RD_BYTE: begin
          // Shift out towards the least significant bit on each falling edge
          if (scl_fall) begin
            if (s_q.bit_cnt[2:0] == sscr_pkg::LAST_OUT_BIT) begin
              // Last bit done: free the pin for the host's acknowledge
              s_d.sda_oe_n = 1'h1;
              s_d.ptr = s_q.ptr + 8'h01;
              s_d.st = ST_RD_ACK;
            end else begin
              s_d.shift = {s_q.shift[6:0], 1'h0};
              s_d.sda_oe_n = s_q.shift[6];
              s_d.bit_cnt = s_q.bit_cnt + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          // Host acknowledge continues the read, a refusal ends it
          if (scl_rise) begin
            s_d.ack_ok = !sda_s;
            if (sda_s) begin
              s_d.st = ST_IDLE;
            end
          end else if (scl_fall && s_q.ack_ok) begin
            // Next byte comes from the advanced pointer; memory has settled
            s_d.bit_cnt = 4'h0;
            s_d.shift = tx_byte;
            s_d.sda_oe_n = tx_byte[7];
            s_d.st = ST_RD_BYTE;
          end
        end
        default: begin
          // Unused codes fall back to idle with the pin released
          s_d.st = ST_IDLE;
          s_d.sda_oe_n = 1'h1;
        end
      endcase
    end
    // Conversions are released only by the start-setup code
    s_d.adc_start = (s_d.setup == sscr_pkg::SETUP_START);
    // Read-gate output registered alongside the disable bit
    s_d.otp_en = !s_d.otp_dis;
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign sda_o = s_q.sda_out;
  assign sda_oe_n_o = s_q.sda_oe_n;
  assign adc_powerup_o = s_q.setup;
  assign adc_setup_start_o = s_q.adc_start;
  assign otp_read_enable_o = s_q.otp_en;

endmodule // sscr_regs_top

`default_nettype wire

// ---- tb/sscr_regs_top_properties.sv ----
/*
  Checker for the register bank's pins and status outputs.
  Assumes it is bound to sscr_regs_top and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none

module sscr_regs_top_properties (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic [1:0] adc_powerup_o,
  input wire logic adc_setup_start_o,
  input wire logic otp_read_enable_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // Pin and status relations
  a_sda_drive_low: assert property (sda_o == 1'b0)
    else $error("data pin output not low");
  a_start_flag_code: assert property (adc_setup_start_o == (adc_powerup_o == 2'h2))
    else $error("start flag disagrees with field");
  a_field_reset_val: assert property ($past(rst_i) |-> adc_powerup_o == 2'h2)
    else $error("power-up field not 10 after reset");
  a_otp_reset_block: assert property ($past(rst_i) |-> !otp_read_enable_o)
    else $error("calibration reads open after reset");
  a_field_scl_low: assert property ($changed(adc_powerup_o) |-> !scl_i)
    else $error("field changed outside a byte end");
  a_otp_scl_low: assert property ($changed(otp_read_enable_o) |-> !scl_i)
    else $error("read gate changed outside a byte end");
  a_oe_scl_low: assert property ($changed(sda_oe_n_o) |-> !scl_i)
    else $error("data pin changed while clock high");
  a_oe_hold_fall: assert property ($fell(scl_i) |-> $stable(sda_oe_n_o) ##1 $stable(sda_oe_n_o))
    else $error("data pin changed too soon after clock fall");
endmodule // sscr_regs_top_properties

`default_nettype wire

// ---- tb/sscr_host_model.sv ----
/*
  Two-wire bus host model: start, stop and byte transfers.
  Assumes an open-drain data wire with pull-up formed by the bench.
*/
`timescale 1ns/100ps
`default_nettype none

module sscr_host_model (
  input wire logic clock_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_n_o
);
  // Bus idle: clock high, data released
  initial begin
    scl_o = 1'b1;
    sda_oe_n_o = 1'b1;
  end

  // Wait n falling clock edges
  task automatic q(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  // Start, also usable as repeated start
  task automatic start();
    sda_oe_n_o = 1'b1;
    q(4);
    scl_o = 1'b1;
    q(8);
    sda_oe_n_o = 1'b0;
    q(8);
    scl_o = 1'b0;
    q(4);
  endtask

  // Stop: data rises while clock high
  task automatic stop();
    sda_oe_n_o = 1'b0;
    q(4);
    scl_o = 1'b1;
    q(8);
    sda_oe_n_o = 1'b1;
    q(8);
  endtask

  // One bit, sampled mid high phase
  task automatic one_bit(input logic b, output logic r);
    sda_oe_n_o = b;
    q(4);
    scl_o = 1'b1;
    q(4);
    r = sda_i;
    q(4);
    scl_o = 1'b0;
    q(4);
  endtask

  // Byte most significant bit first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      one_bit(d[i], r[i]);
    end
    one_bit(ack_in, ack);
  endtask
endmodule // sscr_host_model

`default_nettype wire

// ---- tb/sscr_regs_top_tb.sv ----
/*
  Self-checking bench for the register bank.
  Assumes the host model drives the bus and a pull-up on the data wire.
*/
`timescale 1ns/100ps
`default_nettype none

module sscr_regs_top_tb;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic scl;
  logic host_oe_n;
  logic dut_oe_n;
  logic sda_out;
  logic [1:0] powerup;
  logic start_flag;
  logic otp_en;
  wire logic sda_w;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] rbuf [0:31];

  // Open-drain wire with pull-up
  assign sda_w = host_oe_n & dut_oe_n;

  sscr_regs_top i_sscr_regs_top (.clock_i(clock_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_out), .sda_oe_n_o(dut_oe_n), .adc_powerup_o(powerup),
    .adc_setup_start_o(start_flag), .otp_read_enable_o(otp_en));

  sscr_host_model i_sscr_host_model (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl), .sda_oe_n_o(host_oe_n));

  // Clock and hang limit
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      summarize();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Byte out, device must acknowledge
  task automatic send(input logic [7:0] d);
    logic [7:0] r;
    logic a;
    i_sscr_host_model.xfer(d, 1'b1, r, a);
    check(16'(a), 16'h0000);
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    i_sscr_host_model.start();
    send({sscr_pkg::I2C_DEV_ADDR, 1'b0});
    send(ptr);
    send(d);
    i_sscr_host_model.stop();
  endtask

  // Pointer write, repeated start, n bytes read, last one refused
  task automatic rd(input logic [7:0] ptr, input int n);
    logic a;
    i_sscr_host_model.start();
    send({sscr_pkg::I2C_DEV_ADDR, 1'b0});
    send(ptr);
    i_sscr_host_model.start();
    send({sscr_pkg::I2C_DEV_ADDR, 1'b1});
    for (int i = 0; i < n; i++) begin
      i_sscr_host_model.xfer(8'hff, (i == n - 1), rbuf[i], a);
    end
    i_sscr_host_model.stop();
  endtask

  task automatic t_reset();
    check(16'(powerup), 16'h0002);
    check(16'(start_flag), 16'h0001);
    check(16'(otp_en), 16'h0000);
    rd(sscr_pkg::REG_SETUP, 1);
    check(16'(rbuf[0]), 16'h0002);
    rd(sscr_pkg::REG_OTP_CTRL, 2);
    check({rbuf[0], rbuf[1]}, 16'h6500);
    rd(sscr_pkg::REG_PR_COEFF, 2);
    check({rbuf[0], rbuf[1]}, 16'h0000);
  endtask

  // Only the start code is written, interleaved with read-gate writes that the setup writes must not disturb
  task automatic t_setup();
    logic [7:0] ctrl;
    for (int i = 0; i < 4; i++) begin
      ctrl = i[0] ? 8'h25 : 8'h65;
      wr(sscr_pkg::REG_OTP_CTRL, ctrl);
      wr(sscr_pkg::REG_SETUP, {sscr_pkg::SETUP_RESV, sscr_pkg::SETUP_START});
      check(16'(powerup), 16'(sscr_pkg::SETUP_START));
      check(16'(start_flag), 16'h0001);
      check(16'(otp_en), 16'(!ctrl[sscr_pkg::OTP_DIS_BIT]));
      rd(sscr_pkg::REG_SETUP, 1);
      check(16'(rbuf[0]), 16'(sscr_pkg::SETUP_START));
    end
  endtask

  task automatic t_cal();
    wr(sscr_pkg::REG_OTP_CTRL, 8'h25);
    check(16'(otp_en), 16'h0001);
    rd(sscr_pkg::REG_PR_COEFF, 20);
    for (int i = 0; i < 10; i++) begin
      check({rbuf[2*i], rbuf[2*i+1]}, sscr_pkg::CAL_WORDS[i+1]);
    end
    check(16'(rbuf[18]), 16'(sscr_pkg::CAL_WORDS[10][15:8]));
    check(16'(rbuf[19]), 16'(sscr_pkg::CAL_WORDS[10][7:0]));
    // Writes to calibration words must be dropped
    wr(sscr_pkg::REG_PR_COEFF, ~sscr_pkg::CAL_WORDS[1][15:8]);
    rd(sscr_pkg::REG_PR_COEFF, 2);
    check({rbuf[0], rbuf[1]}, sscr_pkg::CAL_WORDS[1]);
    wr(sscr_pkg::REG_OTP_CTRL, 8'h65);
    check(16'(otp_en), 16'h0000);
    rd(sscr_pkg::REG_EXT, 2);
    check({rbuf[0], rbuf[1]}, 16'h0000);
  endtask

  // Main sequence
  initial begin
    repeat (20) @(negedge clock_i);
    rst_i = 1'b0;
    repeat (5) @(negedge clock_i);
    t_reset();
    t_setup();
    t_cal();
    summarize();
  end
endmodule // sscr_regs_top_tb

bind sscr_regs_top sscr_regs_top_properties i_sscr_regs_top_properties (.clock_i(clock_i), .rst_i(rst_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .adc_powerup_o(adc_powerup_o),
  .adc_setup_start_o(adc_setup_start_o), .otp_read_enable_o(otp_read_enable_o));

`default_nettype wire
